// *** hdl/aic_params.svh ***
// Register offsets, field positions and reset values of the acquisition block
`ifndef AIC_PARAMS_SVH
`define AIC_PARAMS_SVH
`define AIC_OFS_CTRL 12'h000
`define AIC_OFS_CMD 12'h004
`define AIC_OFS_STATUS 12'h008
`define AIC_OFS_DATA 12'h00c
`define AIC_OFS_IRQ_EN 12'h010
`define AIC_OFS_MODE_A 12'h014
`define AIC_OFS_MODE_B 12'h018
`define AIC_OFS_CNT_BASE 12'h020
`define AIC_OFS_CNT_LAST 12'h034
`define AIC_CTRL_W 14
`define AIC_CMD_START 0
`define AIC_CMD_STOP 1
`define AIC_CMD_FLUSH 2
`define AIC_ST_RUNNING 0
`define AIC_ST_NOT_EMPTY 1
`define AIC_ST_HALF 2
`define AIC_ST_FULL 3
`define AIC_ST_OVERFLOW 4
`define AIC_ST_OVERRUN 5
`define AIC_ST_DONE 6
`define AIC_ST_LEVEL_LSB 16
`define AIC_IRQ_AVAIL 0
`define AIC_IRQ_HALF 1
`define AIC_IRQ_DONE 2
`define AIC_GAIN_MAX 3'h6
`define AIC_RST_CTRL 14'h0000
`define AIC_RST_MODE 8'h00
`define AIC_RST_IRQ_EN 3'h0
`define AIC_CNT_A0 0
`define AIC_CNT_A1 1
`define AIC_CNT_A2 2
`define AIC_CNT_B0 3
`define AIC_CNT_B1 4
`define AIC_CNT_B2 5
`endif

// *** hdl/aic_pkg.sv ***
// Types shared by the acquisition block files
package aic_pkg;
   // Acquisition modes
   typedef enum logic [1:0] {
      ACQ_CONTROLLED = 2'h0,
      ACQ_FREERUN = 2'h1,
      ACQ_INTERVAL = 2'h2
   } acq_mode_t;
   // Sequencer states, Gray coded along idle-armed-run-scan wait
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ARMED = 2'h1,
      ST_RUN = 2'h3,
      ST_SCAN_WAIT = 2'h2
   } acq_state_t;
   // Control register layout, MSB first from gain down to scan
   typedef struct packed {
      logic [2:0] gain;
      logic [2:0] chan;
      logic trig_ext;
      logic diff;
      logic dither;
      logic twos;
      acq_mode_t mode;
      logic ext_timing;
      logic scan;
   } ctrl_t;
   // Request carrier towards converter and front end
   typedef struct packed {
      logic start;
      logic [2:0] chan;
      logic [2:0] neg_chan;
      logic neg_en;
      logic [2:0] gain;
      logic dither;
   } conv_ctl_t;
endpackage : aic_pkg

// *** hdl/acq_down_counter.sv ***
// One 16-bit down-counter with clock, gate and terminal output
`timescale 1ns/1ps
`default_nettype none
module acq_down_counter #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic restart,
   input wire logic periodic,
   // Counter pins
   input wire logic tick,
   input wire logic gate,
   // State
   output logic [W-1:0] count,
   output logic term,
   output logic expired
);
   typedef struct packed {
      logic [W-1:0] reload;
      logic [W-1:0] cnt;
      logic expired;
      logic tick_q;
      logic term;
   } dcnt_t;
   dcnt_t s_ff; // Registered state
   dcnt_t nxt_s; // Next state

   // Count rising ticks while gated; one-shot mode parks at zero
   always_comb begin
      nxt_s = s_ff;
      nxt_s.term = 1'b0;
      nxt_s.tick_q = tick;
      if (load) begin
         nxt_s.reload = load_val;
         nxt_s.cnt = load_val;
         nxt_s.expired = (load_val == '0);
      end else if (restart) begin
         nxt_s.cnt = s_ff.reload;
         nxt_s.expired = (s_ff.reload == '0);
      end else if (tick && !s_ff.tick_q && gate && !s_ff.expired) begin
         if (s_ff.cnt <= W'(1)) begin
            nxt_s.term = 1'b1;
            // Periodic reload keeps pulses coming, else stop
            nxt_s.cnt = periodic ? s_ff.reload : '0;
            nxt_s.expired = !periodic;
         end else begin
            nxt_s.cnt = s_ff.cnt - W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign count = s_ff.cnt;
   assign term = s_ff.term;
   assign expired = s_ff.expired;
endmodule : acq_down_counter
`default_nettype wire

// *** hdl/acq_result_fifo.sv ***
// Result FIFO with level flags and overflow detection
`timescale 1ns/1ps
`default_nettype none
module acq_result_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Write side
   input wire logic push,
   input wire logic [W-1:0] din,
   input wire logic flush,
   // Read side
   input wire logic pop,
   output logic [W-1:0] dout,
   // Level
   output logic [AW:0] level,
   output logic full,
   output logic half,
   output logic overflow
);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] lvl;
      logic ovf;
   } fptr_t;
   fptr_t s_ff; // Pointers and level
   fptr_t nxt_s; // Next pointers
   logic [W-1:0] mem [DEPTH]; // Storage
   logic do_push; // Accepted write
   logic do_pop; // Accepted read

   // A push into a full FIFO is dropped and reported
   always_comb begin
      do_push = push && (s_ff.lvl != (AW+1)'(DEPTH));
      do_pop = pop && (s_ff.lvl != '0);
      nxt_s = s_ff;
      nxt_s.ovf = push && !do_push;
      if (flush) begin
         nxt_s.wp = '0;
         nxt_s.rp = '0;
         nxt_s.lvl = '0;
      end else begin
         if (do_push) nxt_s.wp = s_ff.wp + AW'(1);
         if (do_pop) nxt_s.rp = s_ff.rp + AW'(1);
         if (do_push && !do_pop) nxt_s.lvl = s_ff.lvl + (AW+1)'(1);
         if (do_pop && !do_push) nxt_s.lvl = s_ff.lvl - (AW+1)'(1);
      end
   end

   // Pointer register and storage write
   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
      if (do_push && !flush) mem[s_ff.wp] <= din;
   end

   assign dout = mem[s_ff.rp];
   assign level = s_ff.lvl;
   assign full = (s_ff.lvl == (AW+1)'(DEPTH));
   assign half = (s_ff.lvl >= (AW+1)'(DEPTH/2));
   assign overflow = s_ff.ovf;
endmodule : acq_result_fifo
`default_nettype wire

// *** hdl/analog_input_acquisition_control.sv ***
// Analog input acquisition sequencer with APB registers, counters and result FIFO
//
// Overview of operation
// - Two groups of three 16-bit counters, mode registers
// - Group A paces, counts samples, times DAC
// - External strobes may replace A0 and A2 counters
// - B1 or external scan clock time input
// - B2 is a free general-purpose counter
// - Eight channels, programmable gain, 12-bit results
// - Negative mux reaches odd channels only
// - Single-channel channel and gain held throughout
// - Scan counts down from start channel, repeats
// - One gain for every scanned channel
// - Exactly seven gain settings
// - Software dither enable control
// - Each result written to 16x512 FIFO
// - Result into full FIFO flags overflow, lost
// - Straight binary or two's complement coding
// - Results extended to sixteen bits
// - Controlled, freerun, interval; internal or external timing
// - Start by trigger or software; stop by software
// - Sample count gates interval counter off
// - Controlled count limited to sixteen bits
// - Freerun pulses until a software stop, FIFO overflow or overrun ends it
// - Enabled events: data, half full, completion
// - Interval mode: B1 spaces scans, A0 conversions
`timescale 1ns/1ps
`default_nettype none
`include "aic_params.svh"
module analog_input_acquisition_control #(
   parameter int CNT_W = 16,
   parameter int FIFO_DEPTH = 512,
   parameter int FIFO_AW = 9
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter and front end
   output aic_pkg::conv_ctl_t conv_ctl,
   input wire logic adc_done,
   input wire logic [11:0] adc_data,
   // External timing pins
   input wire logic ext_convert_strobe_n,
   input wire logic ext_acq_trigger,
   input wire logic ext_dac_update_n,
   input wire logic ext_scan_clock_in,
   output logic dac_update_n,
   // Counter pins, index A0 A1 A2 B0 B1 B2
   input wire logic [5:0] cnt_clk_in,
   input wire logic [5:0] cnt_gate_in,
   output logic [5:0] cnt_out,
   // Events
   output logic irq,
   output logic acq_running
);
   // Complete registered state of the sequencer
   typedef struct packed {
      aic_pkg::acq_state_t st;
      aic_pkg::ctrl_t ctrl;
      logic [2:0] ch;
      logic [2:0] gain;
      logic busy;
      logic start;
      logic overflow;
      logic overrun;
      logic done;
      logic [2:0] irq_en;
      logic [7:0] mode_a;
      logic [7:0] mode_b;
      logic trig_q;
      logic conv_n_q;
      logic scan_q;
   } seq_t;
   seq_t s_ff; // Registered state
   seq_t nxt_s; // Next state

   logic wr; // APB write access phase
   logic rd; // APB read access phase
   logic hit; // Address decodes to a register
   logic cnt_sel; // Address falls in counter window
   logic [2:0] cnt_idx; // Counter addressed
   logic [5:0] cnt_load; // Counter load strobes
   logic [5:0] cnt_restart; // Counter restart strobes
   logic [5:0] cnt_tick; // Counter clock sources
   logic [5:0] cnt_gate; // Counter gates
   logic [5:0] cnt_periodic; // Counter periodic mode
   logic [5:0] cnt_term; // Counter terminal pulses
   logic [5:0] cnt_exp; // Counter expired flags
   logic [CNT_W-1:0] cnt_val [6]; // Counter values
   logic sw_start; // Software start command
   logic sw_stop; // Software stop command
   logic flush; // FIFO flush command
   logic trig_rise; // External trigger edge
   logic conv_req; // Conversion pulse from selected source
   logic conv_fire; // Conversion pulse allowed by gating
   logic scan_trig; // Start of a scan sequence
   logic gated_off; // Sample count has expired
   logic go; // Operation begins this cycle
   logic [15:0] result; // Extended converter word
   logic fifo_pop; // Data register read
   logic [15:0] fifo_dout; // FIFO head
   logic [FIFO_AW:0] fifo_level; // FIFO level
   logic fifo_full; // FIFO full
   logic fifo_half; // FIFO at least half full
   logic fifo_ovf; // Result dropped in the previous cycle
   logic [31:0] status; // Status word

   // APB decode; the slave never inserts wait states
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign cnt_sel = (paddr >= `AIC_OFS_CNT_BASE) && (paddr <= `AIC_OFS_CNT_LAST)
      && (paddr[1:0] == 2'h0);
   assign cnt_idx = 3'((paddr - `AIC_OFS_CNT_BASE) >> 2);
   assign sw_start = wr && (paddr == `AIC_OFS_CMD) && pwdata[`AIC_CMD_START];
   assign sw_stop = wr && (paddr == `AIC_OFS_CMD) && pwdata[`AIC_CMD_STOP];
   assign flush = wr && (paddr == `AIC_OFS_CMD) && pwdata[`AIC_CMD_FLUSH];
   assign fifo_pop = rd && (paddr == `AIC_OFS_DATA);

   // Register hit test; unmapped addresses answer with an error
   always_comb begin
      case (paddr)
         `AIC_OFS_CTRL, `AIC_OFS_CMD, `AIC_OFS_STATUS, `AIC_OFS_DATA,
         `AIC_OFS_IRQ_EN, `AIC_OFS_MODE_A, `AIC_OFS_MODE_B: hit = 1'b1;
         default: hit = cnt_sel;
      endcase
   end
   assign pslverr = psel && penable && !hit;

   // Edge detection on the external timing pins
   assign trig_rise = ext_acq_trigger && !s_ff.trig_q;
   // Conversion source: A0 terminal or external strobe falling edge
   assign conv_req = s_ff.ctrl.ext_timing ? (s_ff.conv_n_q && !ext_convert_strobe_n)
      : cnt_term[`AIC_CNT_A0];
   // Scan interval: B1 terminal or external scan clock rising edge
   assign scan_trig = s_ff.ctrl.ext_timing ? (ext_scan_clock_in && !s_ff.scan_q)
      : cnt_term[`AIC_CNT_B1];
   // Sample count only limits controlled mode
   assign gated_off = (s_ff.ctrl.mode == aic_pkg::ACQ_CONTROLLED) && cnt_exp[`AIC_CNT_A1];
   assign conv_fire = (s_ff.st == aic_pkg::ST_RUN) && conv_req && !gated_off;
   // Operation starts from software or from the armed trigger
   assign go = (s_ff.st == aic_pkg::ST_IDLE && sw_start && !s_ff.ctrl.trig_ext)
      || (s_ff.st == aic_pkg::ST_ARMED && trig_rise);

   // Result coding: zero-extend binary, sign-extend two's complement
   assign result = s_ff.ctrl.twos ? {{4{adc_data[11]}}, adc_data}
      : {4'h0, adc_data};

   // Counter wiring per index
   always_comb begin
      cnt_tick = cnt_clk_in;
      cnt_gate = cnt_gate_in;
      cnt_restart = 6'h00;
      cnt_periodic = {s_ff.mode_b[2:0], s_ff.mode_a[2:0]};
      // A0 paces conversions, gated off by A1 expiry
      cnt_gate[`AIC_CNT_A0] = (s_ff.st == aic_pkg::ST_RUN) && !gated_off;
      cnt_restart[`AIC_CNT_A0] = go || ((s_ff.st == aic_pkg::ST_SCAN_WAIT) && scan_trig);
      // A1 counts accepted conversions, one-shot
      cnt_tick[`AIC_CNT_A1] = conv_fire;
      cnt_gate[`AIC_CNT_A1] = (s_ff.st == aic_pkg::ST_RUN);
      cnt_periodic[`AIC_CNT_A1] = 1'b0;
      cnt_restart[`AIC_CNT_A1] = go;
      // B1 free pin counter unless spacing scans
      if (s_ff.ctrl.mode == aic_pkg::ACQ_INTERVAL && s_ff.st != aic_pkg::ST_IDLE) begin
         cnt_gate[`AIC_CNT_B1] = 1'b1;
         cnt_periodic[`AIC_CNT_B1] = 1'b1;
         cnt_restart[`AIC_CNT_B1] = go;
      end
      // B2 stays wired to its pins only
   end

   // Six counters, loaded by software writes
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_cnt
         assign cnt_load[gi] = wr && cnt_sel && (cnt_idx == 3'(gi));
         acq_down_counter #(.W(CNT_W)) u_cnt (
            .clk(clk),
            .rst(rst),
            .load(cnt_load[gi]),
            .load_val(pwdata[CNT_W-1:0]),
            .restart(cnt_restart[gi]),
            .periodic(cnt_periodic[gi]),
            .tick(cnt_tick[gi]),
            .gate(cnt_gate[gi]),
            .count(cnt_val[gi]),
            .term(cnt_term[gi]),
            .expired(cnt_exp[gi])
         );
      end
   endgenerate
   assign cnt_out = cnt_term;

   // Result store; every finished conversion is pushed
   acq_result_fifo #(.W(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .clk(clk),
      .rst(rst),
      .push(adc_done),
      .din(result),
      .flush(flush),
      .pop(fifo_pop),
      .dout(fifo_dout),
      .level(fifo_level),
      .full(fifo_full),
      .half(fifo_half),
      .overflow(fifo_ovf)
   );

   // Sequencer, control registers and sticky flags
   always_comb begin
      nxt_s = s_ff;
      nxt_s.start = 1'b0;
      nxt_s.trig_q = ext_acq_trigger;
      nxt_s.conv_n_q = ext_convert_strobe_n;
      nxt_s.scan_q = ext_scan_clock_in;
      // Control writes; gain code 7 saturates to the top setting
      if (wr && paddr == `AIC_OFS_CTRL) begin
         nxt_s.ctrl = aic_pkg::ctrl_t'(pwdata[`AIC_CTRL_W-1:0]);
         if (pwdata[`AIC_CTRL_W-1 -: 3] > `AIC_GAIN_MAX) nxt_s.ctrl.gain = `AIC_GAIN_MAX;
         if (pwdata[3:2] == 2'h3) nxt_s.ctrl.mode = aic_pkg::ACQ_CONTROLLED;
      end
      if (wr && paddr == `AIC_OFS_IRQ_EN) nxt_s.irq_en = pwdata[2:0];
      if (wr && paddr == `AIC_OFS_MODE_A) nxt_s.mode_a = pwdata[7:0];
      if (wr && paddr == `AIC_OFS_MODE_B) nxt_s.mode_b = pwdata[7:0];
      // Write-one clears first so that a new event below wins
      if (wr && paddr == `AIC_OFS_STATUS) begin
         if (pwdata[`AIC_ST_OVERFLOW]) nxt_s.overflow = 1'b0;
         if (pwdata[`AIC_ST_OVERRUN]) nxt_s.overrun = 1'b0;
         if (pwdata[`AIC_ST_DONE]) nxt_s.done = 1'b0;
      end
      // Converter busy tracking
      if (adc_done) nxt_s.busy = 1'b0;
      if (conv_fire && !s_ff.busy) begin
         nxt_s.busy = 1'b1;
         nxt_s.start = 1'b1;
      end
      // Pulse while converter busy is an overrun
      if (conv_fire && s_ff.busy) nxt_s.overrun = 1'b1;
      if (fifo_ovf) nxt_s.overflow = 1'b1;
      // Channel advance after each result in scan mode
      if (adc_done && s_ff.st == aic_pkg::ST_RUN && s_ff.ctrl.scan) begin
         nxt_s.ch = (s_ff.ch == 3'h0) ? s_ff.ctrl.chan : s_ff.ch - 3'h1;
      end
      case (s_ff.st)
         aic_pkg::ST_IDLE: begin
            // Start channel and gain are loaded here; gain holds for the whole run
            if (sw_start) begin
               nxt_s.ch = s_ff.ctrl.chan;
               nxt_s.gain = s_ff.ctrl.gain;
               nxt_s.done = 1'b0;
               nxt_s.st = s_ff.ctrl.trig_ext ? aic_pkg::ST_ARMED
                  : (s_ff.ctrl.mode == aic_pkg::ACQ_INTERVAL)
                  ? aic_pkg::ST_SCAN_WAIT : aic_pkg::ST_RUN;
            end
         end
         aic_pkg::ST_ARMED: begin
            // Waiting on the external trigger edge
            if (trig_rise) begin
               nxt_s.st = (s_ff.ctrl.mode == aic_pkg::ACQ_INTERVAL)
                  ? aic_pkg::ST_SCAN_WAIT : aic_pkg::ST_RUN;
            end
         end
         aic_pkg::ST_RUN: begin
            // Controlled run ends once count expires and converter idles
            if (gated_off && !s_ff.busy && !adc_done) begin
               nxt_s.st = aic_pkg::ST_IDLE;
               nxt_s.done = 1'b1;
            end else if (adc_done && s_ff.ctrl.mode == aic_pkg::ACQ_INTERVAL
                         && (s_ff.ch == 3'h0 || !s_ff.ctrl.scan)) begin
               nxt_s.st = aic_pkg::ST_SCAN_WAIT;
            end
         end
         aic_pkg::ST_SCAN_WAIT: begin
            // Next scan begins on the scan interval pulse
            if (scan_trig) nxt_s.st = aic_pkg::ST_RUN;
         end
         default: nxt_s.st = aic_pkg::ST_IDLE;
      endcase
      // Software stop and error conditions end the operation
      if (s_ff.st != aic_pkg::ST_IDLE && (sw_stop || fifo_ovf || (conv_fire && s_ff.busy))) begin
         nxt_s.st = aic_pkg::ST_IDLE;
         nxt_s.done = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= '0;
         s_ff.ctrl <= aic_pkg::ctrl_t'(`AIC_RST_CTRL);
         s_ff.irq_en <= `AIC_RST_IRQ_EN;
         s_ff.mode_a <= `AIC_RST_MODE;
         s_ff.mode_b <= `AIC_RST_MODE;
         s_ff.trig_q <= 1'b0;
         s_ff.conv_n_q <= 1'b1;
         s_ff.scan_q <= 1'b0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Converter and multiplexer outputs; differential mate is the odd channel
   always_comb begin
      conv_ctl.start = s_ff.start;
      conv_ctl.chan = s_ff.ch;
      conv_ctl.neg_chan = {s_ff.ch[2:1], 1'b1};
      conv_ctl.neg_en = s_ff.ctrl.diff;
      conv_ctl.gain = s_ff.gain;
      conv_ctl.dither = s_ff.ctrl.dither;
   end

   // DAC update from A2 or the external update strobe
   assign dac_update_n = s_ff.ctrl.ext_timing ? ext_dac_update_n
      : !cnt_term[`AIC_CNT_A2];
   assign acq_running = (s_ff.st != aic_pkg::ST_IDLE);

   // Event line from enabled status conditions
   assign irq = (s_ff.irq_en[`AIC_IRQ_AVAIL] && fifo_level != '0)
      || (s_ff.irq_en[`AIC_IRQ_HALF] && fifo_half)
      || (s_ff.irq_en[`AIC_IRQ_DONE] && s_ff.done);

   // Status word
   always_comb begin
      status = 32'h0000_0000;
      status[`AIC_ST_RUNNING] = acq_running;
      status[`AIC_ST_NOT_EMPTY] = (fifo_level != '0);
      status[`AIC_ST_HALF] = fifo_half;
      status[`AIC_ST_FULL] = fifo_full;
      status[`AIC_ST_OVERFLOW] = s_ff.overflow;
      status[`AIC_ST_OVERRUN] = s_ff.overrun;
      status[`AIC_ST_DONE] = s_ff.done;
      status[`AIC_ST_LEVEL_LSB +: FIFO_AW+1] = fifo_level;
   end

   // Read mux; unmapped and write cycles return zero
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            `AIC_OFS_CTRL: prdata[`AIC_CTRL_W-1:0] = s_ff.ctrl;
            `AIC_OFS_STATUS: prdata = status;
            `AIC_OFS_DATA: prdata[15:0] = (fifo_level != '0) ? fifo_dout : 16'h0000;
            `AIC_OFS_IRQ_EN: prdata[2:0] = s_ff.irq_en;
            `AIC_OFS_MODE_A: prdata[7:0] = s_ff.mode_a;
            `AIC_OFS_MODE_B: prdata[7:0] = s_ff.mode_b;
            default: begin
               if (cnt_sel) prdata[CNT_W-1:0] = cnt_val[cnt_idx];
            end
         endcase
      end
   end
endmodule : analog_input_acquisition_control
`default_nettype wire

// *** testbench/acq_ctl_asserts.sv ***
// Port assertions for the acquisition block
`timescale 1ns/1ps
`default_nettype none
module acq_ctl_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Converter side
   input wire aic_pkg::conv_ctl_t conv_ctl,
   input wire logic adc_done,
   input wire logic [5:0] cnt_out,
   input wire logic acq_running
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Pacing terminal seen while a run is active
   sequence pace_s; cnt_out[0] && acq_running; endsequence
   // One-cycle conversion request
   sequence req_s; conv_ctl.start ##1 !conv_ctl.start; endsequence
   // Run settled three cycles, so the load of channel and gain is past
   sequence hold_s; acq_running && $past(acq_running) && $past(acq_running, 2); endsequence
   bus_ready_a: assert property (psel && penable |-> pready) else $error("access stalled");
   read_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside a read");
   bad_addr_a: assert property (psel && penable && (paddr == 12'h01c || paddr > 12'h034)
      |-> pslverr) else $error("unmapped access not refused");
   pace_conv_a: assert property (pace_s |=> req_s) else $error("tick gave no request");
   gain_hold_a: assert property (hold_s |-> $stable(conv_ctl.gain))
      else $error("gain moved");
   chan_hold_a: assert property (
      hold_s and !$past(adc_done) |-> $stable(conv_ctl.chan)) else $error("channel moved");
   chan_step_a: assert property (
      hold_s and $changed(conv_ctl.chan) |-> conv_ctl.chan == $past(conv_ctl.chan) - 3'h1
      || $past(conv_ctl.chan) == 3'h0) else $error("channel did not step down");
   gain_max_a: assert property (conv_ctl.gain <= 3'h6) else $error("gain out of range");
   neg_odd_a: assert property (
      conv_ctl.neg_en |-> conv_ctl.neg_chan == {conv_ctl.chan[2:1], 1'b1})
      else $error("mate not odd");
   start_run_a: assert property (conv_ctl.start |-> $past(acq_running))
      else $error("request while idle");
endmodule : acq_ctl_asserts
bind analog_input_acquisition_control acq_ctl_asserts chk (.clk, .rst, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .conv_ctl, .adc_done, .cnt_out, .acq_running);
`default_nettype wire

// *** testbench/adc_model.sv ***
// Behavioural converter answering each request after a set delay
`timescale 1ns/1ps
`default_nettype none
module adc_model #(
   parameter int DLY = 2
) (
   // Clock
   input wire logic clk,
   // Request from the block
   input wire aic_pkg::conv_ctl_t conv_ctl,
   // Result to the block
   output logic adc_done,
   output logic [11:0] adc_data
);
   int cnt_ff = 0; // Cycles left in the conversion
   logic [2:0] ch_ff = 3'h0; // Channel latched at the request
   initial adc_done = 1'b0;
   initial adc_data = 12'h000;
   // Result carries the channel so scan order shows in the data
   always @(posedge clk) begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data; // Bus toggles between results, never stale
      if (conv_ctl.start) begin
         cnt_ff <= DLY;
         ch_ff <= conv_ctl.chan;
      end else if (cnt_ff != 0) begin
         cnt_ff <= cnt_ff - 1;
         if (cnt_ff == 1) begin
            adc_done <= 1'b1;
            adc_data <= {1'b1, 8'h5a, ch_ff};
         end
      end
   end
endmodule : adc_model
`default_nettype wire

// *** testbench/tb_analog_input_acquisition_control.sv ***
// Self-checking bench for the acquisition block
`timescale 1ns/1ps
`default_nettype none
`include "aic_params.svh"
module tb_analog_input_acquisition_control;
   logic clk = 1'b0; // Bench clock
   logic rst = 1'b1; // Synchronous reset
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus request
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, adc_done, irq, running;
   logic trig = 1'b0; // External start pin
   logic [11:0] adc_data;
   logic [5:0] cnt_clk = 6'h00; // Counter clock pins
   aic_pkg::conv_ctl_t conv_ctl;
   int fail_count = 0, n_tests = 0;
   initial forever #2 clk = ~clk;
   analog_input_acquisition_control uut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_ctl(conv_ctl), .adc_done(adc_done),
      .adc_data(adc_data), .ext_convert_strobe_n(1'b1), .ext_acq_trigger(trig),
      .ext_dac_update_n(1'b1), .ext_scan_clock_in(1'b0), .dac_update_n(),
      .cnt_clk_in(cnt_clk), .cnt_gate_in(6'h3f), .cnt_out(), .irq(irq), .acq_running(running));
   adc_model adc (.clk(clk), .conv_ctl(conv_ctl), .adc_done(adc_done), .adc_data(adc_data));
   // Expected FIFO word: model pattern, extended by the coding
   function automatic logic [31:0] res(input logic [2:0] ch, input logic tw);
      return {16'h0, {4{tw}}, 1'b1, 8'h5a, ch};
   endfunction : res
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   // One transfer; holds until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Edges on the interval counter clock, slow enough for the converter
   task automatic tick(input int n);
      repeat (n) begin
         cnt_clk[0] <= 1'b1;
         repeat (4) @(posedge clk);
         cnt_clk[0] <= 1'b0;
         repeat (4) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask : tick
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   // Hang guard, well above the expected run
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(0, `AIC_OFS_STATUS, 0);
      check(rd, 32'h0, "status reset");
      apb(1, 12'h01c, 1);
      check(32'(err), 32'h1, "slverr");
      apb(1, `AIC_OFS_CTRL, 32'h3800);
      apb(0, `AIC_OFS_CTRL, 0);
      check(rd, 32'h3000, "gain clamp");
      // Controlled scan from channel 3, three samples, two's complement, gain 7 clamped
      apb(1, `AIC_OFS_MODE_A, 1);
      apb(1, `AIC_OFS_CNT_BASE, 2);
      apb(1, `AIC_OFS_CNT_BASE + 12'h4, 3);
      apb(1, `AIC_OFS_IRQ_EN, 4);
      apb(1, `AIC_OFS_CTRL, 32'h3b71);
      apb(1, `AIC_OFS_CMD, 1);
      tick(6);
      for (int i = 3; i > 0; i--) begin
         apb(0, `AIC_OFS_DATA, 0);
         check(rd, res(3'(i), 1'b1), "scan data");
      end
      apb(0, `AIC_OFS_STATUS, 0);
      check(rd, 32'h40, "done status");
      check(32'(irq), 32'h1, "irq set");
      apb(1, `AIC_OFS_STATUS, 32'h70);
      check(32'(irq), 32'h0, "irq clear");
      // Freerun on channel 5, started by the external trigger, stopped by command
      apb(1, `AIC_OFS_CTRL, 32'h584);
      apb(1, `AIC_OFS_CMD, 1);
      check(32'(running), 32'h1, "armed");
      trig <= 1'b1;
      @(posedge clk);
      tick(4);
      apb(1, `AIC_OFS_CMD, 2);
      repeat (2) begin
         apb(0, `AIC_OFS_DATA, 0);
         check(rd, res(3'h5, 1'b0), "freerun data");
      end
      check(32'(running), 32'h0, "stopped");
      // Fill past 512 words: overflow sticks until cleared
      apb(1, `AIC_OFS_CNT_BASE, 1);
      apb(1, `AIC_OFS_CTRL, 32'h4);
      apb(1, `AIC_OFS_CMD, 1);
      tick(513);
      apb(0, `AIC_OFS_STATUS, 0);
      check(rd, 32'h0200005e, "overflow");
      apb(0, `AIC_OFS_DATA, 0);
      check(rd, res(3'h0, 1'b0), "oldest");
      apb(1, `AIC_OFS_STATUS, 32'h70);
      apb(0, `AIC_OFS_STATUS, 0);
      check(rd, 32'h01ff0006, "cleared");
      apb(1, `AIC_OFS_CMD, 4);
      apb(0, `AIC_OFS_STATUS, 0);
      check(rd, 32'h0, "flushed");
      finish_test();
   end
endmodule : tb_analog_input_acquisition_control
`default_nettype wire
